// file: rtl/ter_pkg.sv
// shared constants and carrier types for the tamper event recorder
package ter_pkg;
  localparam int unsigned CHANNELS = 3;
  localparam int unsigned TIME_W = 32;
  localparam int unsigned COUNT_W = 16;
  localparam logic [31:0] TIME_RESET = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // per-channel record as seen by the outside
  typedef struct packed {
    logic [TIME_W-1:0] first_time;
    logic [TIME_W-1:0] last_time;
    logic [COUNT_W-1:0] count;
  } ter_record_t;

  // system-side power and enable levels
  typedef struct packed {
    logic sys_running;
    logic irq_enable;
    logic wake_enable;
  } ter_sys_t;
endpackage

// file: rtl/ter_recorder.sv
// tamper event recorder: edge detect, counters, first and last timestamps
`timescale 1ns/1ps
`default_nettype none

module ter_recorder #(
  parameter int unsigned CHANNELS = ter_pkg::CHANNELS
) (
  // clock and reset from the backup domain
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // sensor pins and time base
  input wire logic [CHANNELS-1:0] event_input_pin_in,
  input wire logic [ter_pkg::TIME_W-1:0] rtc_time_in,
  // system side
  input wire ter_pkg::ter_sys_t sys_in,
  input wire logic [CHANNELS-1:0] flag_clear_in,
  input wire logic record_clear_in,
  // records and signals out
  output var ter_pkg::ter_record_t [CHANNELS-1:0] record_out,
  output logic [CHANNELS-1:0] gpio_flags_out,
  output logic irq_out,
  output logic wake_out
);

  // edge history and per-channel working state
  logic [CHANNELS-1:0] pin_prev;
  logic [CHANNELS-1:0] pin_armed;
  logic [CHANNELS-1:0] event_hit;
  logic [CHANNELS-1:0] chan_empty;
  logic [CHANNELS-1:0] take_first;
  logic [CHANNELS-1:0] flags;
  logic [CHANNELS-1:0] next_flags;
  logic any_flag;
  logic next_irq;
  logic next_wake;
  logic [ter_pkg::TIME_W-1:0] first_time [CHANNELS];
  logic [ter_pkg::TIME_W-1:0] last_time [CHANNELS];
  logic [ter_pkg::COUNT_W-1:0] count [CHANNELS];
  logic [ter_pkg::COUNT_W-1:0] next_count [CHANNELS];
  ter_pkg::ter_record_t [CHANNELS-1:0] rec;

  // arming: the first edge after reset only loads history
  typedef enum logic {ARM_WAIT, ARM_LIVE} ter_arm_state_t;
  ter_arm_state_t arm_state;
  ter_arm_state_t next_arm_state;

  // a full counter stays full rather than wrapping
  function automatic logic [ter_pkg::COUNT_W-1:0] sat_inc(
    input logic [ter_pkg::COUNT_W-1:0] value
  );
    if (value == ter_pkg::COUNT_MAX)
      return value;
    return value + ter_pkg::COUNT_ONE;
  endfunction

  // level change in either direction on an armed channel
  function automatic logic [CHANNELS-1:0] level_change(
    input logic [CHANNELS-1:0] now,
    input logic [CHANNELS-1:0] prev,
    input logic [CHANNELS-1:0] armed
  );
    return (now ^ prev) & armed;
  endfunction

  function automatic logic is_empty(
    input logic [ter_pkg::COUNT_W-1:0] value
  );
    return value == ter_pkg::COUNT_RESET;
  endfunction

  always_comb
  begin
    case (arm_state)
      ARM_WAIT: next_arm_state = ARM_LIVE;
      ARM_LIVE: next_arm_state = ARM_LIVE;
      default: next_arm_state = ARM_WAIT;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      arm_state <= ARM_WAIT;
    end
    else
    begin
      arm_state <= next_arm_state;
    end
  end

  always_comb
  begin
    pin_armed = {CHANNELS{arm_state == ARM_LIVE}};
  end

  // previous pin levels
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pin_prev <= '0;
    end
    else
    begin
      pin_prev <= event_input_pin_in;
    end
  end

  // both directions count; channels are independent
  always_comb
  begin
    event_hit = level_change(event_input_pin_in, pin_prev, pin_armed);
  end

  always_comb
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      chan_empty[i] = is_empty(count[i]);
    end
  end

  // an event in the clear cycle starts a fresh record
  always_comb
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      take_first[i] = event_hit[i]
        && (chan_empty[i] || record_clear_in);
    end
  end

  always_comb
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (record_clear_in)
        next_count[i] = ter_pkg::COUNT_RESET;
      else
        next_count[i] = count[i];
      if (event_hit[i])
        next_count[i] = sat_inc(next_count[i]);
    end
  end

  // event counters, kept whatever the system power state
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        count[i] <= ter_pkg::COUNT_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        count[i] <= next_count[i];
      end
    end
  end

  // first-event timestamp, taken only into an empty record or in the record clear cycle
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        first_time[i] <= ter_pkg::TIME_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        if (take_first[i])
          first_time[i] <= rtc_time_in;
        else if (record_clear_in)
          first_time[i] <= ter_pkg::TIME_RESET;
      end
    end
  end

  // last-event timestamp follows every event
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        last_time[i] <= ter_pkg::TIME_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        if (event_hit[i])
          last_time[i] <= rtc_time_in;
        else if (record_clear_in)
          last_time[i] <= ter_pkg::TIME_RESET;
      end
    end
  end

  // sticky flags; a same-cycle event beats the clear
  always_comb
  begin
    next_flags = (flags & ~flag_clear_in) | event_hit;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      flags <= '0;
    end
    else
    begin
      flags <= next_flags;
    end
  end

  // interrupt only while running, wake only while off
  always_comb
  begin
    any_flag = |flags;
    next_irq = any_flag && sys_in.irq_enable && sys_in.sys_running;
    next_wake = any_flag && sys_in.wake_enable && !sys_in.sys_running;
  end

  // gather per-channel state into the outward record
  always_comb
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      rec[i].first_time = first_time[i];
      rec[i].last_time = last_time[i];
      rec[i].count = count[i];
    end
  end

  // registered outputs, record one cycle behind
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      record_out <= '0;
    end
    else
    begin
      record_out <= rec;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      gpio_flags_out <= '0;
    end
    else
    begin
      gpio_flags_out <= flags;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= next_irq;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wake_out <= 1'b0;
    end
    else
    begin
      wake_out <= next_wake;
    end
  end
endmodule
`default_nettype wire

// file: sim/ter_recorder_assertions.sv
// checker for the tamper event recorder: channel 0 record and flag, plus irq and wake over all flags
`timescale 1ns/1ps
`default_nettype none
module ter_recorder_chk (
  input wire logic ref_clk_in, arst_n_in, record_clear_in, irq_out, wake_out,
  input wire logic [2:0] event_input_pin_in, gpio_flags_out,
  input wire logic [31:0] rtc_time_in,
  input wire ter_pkg::ter_sys_t sys_in,
  input wire ter_pkg::ter_record_t [2:0] record_out
);
  logic p;
  wire logic e = event_input_pin_in[0] ^ p;
  wire logic k = !record_clear_in;
  wire ter_pkg::ter_record_t r = record_out[0];
  wire logic [2:0] s = sys_in;
  always_ff @(posedge ref_clk_in) p <= event_input_pin_in[0];
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  // record_out trails the working record by one cycle
  property p_c;
    e && k ##1 r.count != 16'hffff |=> r.count == $past(r.count) + 16'h1;
  endproperty
  property p_l;
    e && k |=> ##1 r.last_time == $past(rtc_time_in, 2);
  endproperty
  property p_f;
    e && k ##1 r.count != 16'h0 |=> $stable(r.first_time);
  endproperty
  property p_n;
    e ##1 r.count == 16'h0 |=> r.first_time == $past(rtc_time_in, 2);
  endproperty
  property p_g;
    e |=> ##1 gpio_flags_out[0];
  endproperty
  property p_h;
    !e && k |=> ##1 $stable(r);
  endproperty
  property p_i;
    irq_out == (|gpio_flags_out && $past(s[2]) && $past(s[1]));
  endproperty
  property p_w;
    wake_out == (|gpio_flags_out && !$past(s[2]) && $past(s[0]));
  endproperty
  a_c: assert property (p_c) else $error("count");
  a_l: assert property (p_l) else $error("last");
  a_f: assert property (p_f) else $error("first kept");
  a_n: assert property (p_n) else $error("first taken");
  a_g: assert property (p_g) else $error("flag");
  a_h: assert property (p_h) else $error("hold");
  a_i: assert property (p_i) else $error("irq");
  a_w: assert property (p_w) else $error("wake");
  c_i: cover property (irq_out);
  c_w: cover property (wake_out);
  c_r: cover property (record_clear_in);
endmodule
bind ter_recorder ter_recorder_chk ter_recorder_chk_i (.*);
`default_nettype wire

// file: sim/ter_sensor_model.sv
// sensor stand-in: flips event pins on command at the falling edge
`timescale 1ns/1ps
`default_nettype none
module ter_sensor_model (
  input wire logic ref_clk_in,
  input wire logic [2:0] toggle_in,
  output var logic [2:0] event_input_pin_out = 3'h0
);
  always @(negedge ref_clk_in)
    event_input_pin_out <= event_input_pin_out ^ toggle_in;
endmodule
`default_nettype wire

// file: sim/tamper_event_recorder_tb_top.sv
// self-checking bench for the tamper event recorder
`timescale 1ns/1ps
`default_nettype none
module tamper_event_recorder_tb_top;
  logic ref_clk_in = 0, arst_n_in = 0, record_clear_in = 0;
  logic irq_out, wake_out;
  logic [2:0] event_input_pin_in, gpio_flags_out, flag_clear_in = 0, tg = 0;
  logic [31:0] rtc_time_in = 0, r;
  ter_pkg::ter_sys_t sys_in = 0;
  ter_pkg::ter_record_t [2:0] record_out;
  int err_count = 0, checks = 0, cyc = 0;
  always #12.5 ref_clk_in = !ref_clk_in;
  always @(negedge ref_clk_in) rtc_time_in <= rtc_time_in + 32'h11;
  ter_sensor_model ter_sensor_model_i (.ref_clk_in, .toggle_in(tg),
    .event_input_pin_out(event_input_pin_in));
  ter_recorder ter_recorder_i (.*);
  task automatic chk(input logic [79:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // n pin flips per set bit of m, one per cycle, then settle
  task automatic go(input logic [2:0] m, input int n);
    r = rtc_time_in;
    tg <= m;
    repeat (n) @(negedge ref_clk_in);
    tg <= 3'h0;
    repeat (3) @(negedge ref_clk_in);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_rec;
    logic [31:0] f;
    go(3'h5, 3);
    f = r + 32'h22;
    chk(record_out[0], {f, r + 32'h44, 16'h3});
    chk(record_out[2], {f, r + 32'h44, 16'h3});
    chk(record_out[1], 80'h0);
    go(3'h1, 1);
    chk(record_out[0], {f, r + 32'h22, 16'h4});
    record_clear_in <= 1'b1;
    @(negedge ref_clk_in);
    record_clear_in <= 1'b0;
    go(3'h1, 1);
    chk(record_out[0], {r + 32'h22, r + 32'h22, 16'h1});
    $display("record test done");
  endtask
  task automatic t_sys;
    sys_in <= 3'h6;
    go(3'h2, 1);
    chk({gpio_flags_out, irq_out, wake_out}, 5'h1e);
    flag_clear_in <= 3'h7;
    @(negedge ref_clk_in);
    flag_clear_in <= 3'h0;
    repeat (3) @(negedge ref_clk_in);
    chk({gpio_flags_out, irq_out}, 4'h0);
    sys_in <= 3'h1;
    go(3'h4, 1);
    chk({gpio_flags_out, irq_out, wake_out}, 5'h11);
    chk(record_out[2].count, 16'h1);
    $display("system test done");
  endtask
  // event in the same cycle as both clears
  task automatic t_race;
    r = rtc_time_in;
    tg <= 3'h1;
    @(negedge ref_clk_in);
    tg <= 3'h0;
    flag_clear_in <= 3'h7;
    record_clear_in <= 1'b1;
    @(negedge ref_clk_in);
    flag_clear_in <= 3'h0;
    record_clear_in <= 1'b0;
    repeat (3) @(negedge ref_clk_in);
    chk(gpio_flags_out, 3'h1);
    chk(record_out[0], {r + 32'h22, r + 32'h22, 16'h1});
    chk(record_out[2], 80'h0);
    $display("race test done");
  endtask
  // second reset with a pin held high: no false edge after it
  task automatic t_rst;
    arst_n_in <= 1'b0;
    repeat (2) @(negedge ref_clk_in);
    arst_n_in <= 1'b1;
    chk({gpio_flags_out, irq_out, wake_out}, 5'h0);
    repeat (3) @(negedge ref_clk_in);
    chk(record_out[1], 80'h0);
    chk({gpio_flags_out, irq_out, wake_out}, 5'h0);
    $display("reset test done");
  endtask
  initial
  begin
    repeat (10) @(negedge ref_clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(negedge ref_clk_in);
    t_rec();
    t_sys();
    t_race();
    t_rst();
    test_done();
  end
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 500)
    begin
      err_count++;
      test_done();
    end
  end
endmodule
`default_nettype wire
